// file: common/secure_region_pkg.sv
// constants, types and command codes for the secure region access block
// assumes one 20 MHz clock and a word-wide host command port
// Function
// - secure region holds 256 words: 128 factory, 128 customer
// - factory words at 00h-7Fh, customer words at 80h-FFh
// - secure reads beyond 256 words return invalid data
// - factory lock flag reads 1 on bit 7 at id address 03h
// - customer lock flag on bit 6, 0 unlocked, 1 forever once locked
// - secure mode allows simultaneous operations in all banks but bank 0
// - reset returns device to normal array space
// - secure reads in async and sync modes; bursts wrap FFh to 00h
// - secure mode overlays sector 0; other sectors read array data
// - secure region inaccessible while embedded program or erase runs
// - customer part programmed once, locked once, never unlocked
// - no accelerated or bypass programming during customer program
// - exit sequence is AA@555, 55@2AA, 90@555
// - secure mode persists until exit or reset
// - continuous burst past top address gives undefined data
package secure_region_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REGION_WORDS = 256;
  localparam int REGION_AW = 8;
  localparam int SECTOR0_AW = 15;
  localparam int BANK_W = 4;
  localparam logic [ADDR_W-1:0] MAX_ADDR = 24'hffffff;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] CMD_ENTRY = 16'h0088;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_EXIT = 16'h0090;
  localparam logic [15:0] CMD_LOCK = 16'h0060;
  localparam logic [7:0] CUST_BASE = 8'h80;
  localparam logic [7:0] ID_LOCK_ADDR = 8'h03;
  localparam int FACT_FLAG_BIT = 7;
  localparam int CUST_FLAG_BIT = 6;
  localparam logic [15:0] INVALID_DATA = 16'hffff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_cycle_s;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } rd_word_s;

  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_UNLK1 = 5'h02,
    SEQ_UNLK2 = 5'h04,
    SEQ_PROG = 5'h08,
    SEQ_LOCK = 5'h10
  } seq_e;
endpackage

// file: rtl/secure_region_access.sv
// secure region overlay, command decoder and burst wrap
// assumes host write/read strobes synchronous to core_clk_in
`timescale 1ns/1ps
`default_nettype none
module secure_region_access (
  input wire logic core_clk_in, // 20 MHz clock
  input wire logic srst_in, // sync reset, high
  input wire logic wr_in, // command write strobe
  input wire secure_region_pkg::wr_cycle_s wr_cyc_in, // write addr/data
  input wire logic rd_in, // read strobe
  input wire logic [secure_region_pkg::ADDR_W-1:0] rd_addr_in, // read addr
  input wire logic burst_start_in, // start sync burst at rd_addr_in
  input wire logic burst_next_in, // advance burst one word
  input wire logic id_rd_in, // identification read at rd_addr_in
  input wire logic embedded_busy_in, // array program/erase running
  input wire logic [secure_region_pkg::DATA_W-1:0] array_data_in, // array
  input wire logic [secure_region_pkg::BANK_W-1:0] op_bank_in, // bank
  output secure_region_pkg::rd_word_s rd_out, // read result
  output logic [secure_region_pkg::ADDR_W-1:0] array_addr_out, // array addr
  output logic secure_mode_out, // secure overlay active
  output logic bank_op_allow_out, // simultaneous op allowed
  output logic accel_allow_out, // accelerated/bypass allowed
  output logic prog_busy_out, // customer program under way
  output logic customer_lock_flag_out // customer part locked
);
  import secure_region_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic is_cyc(input wr_cycle_s c, input logic [11:0] a,
                                  input logic [15:0] d);
    is_cyc = (c.addr[11:0] == a) && (c.data == d);
  endfunction

  logic [DATA_W-1:0] mem_r [REGION_WORDS];
  // nonvolatile marks: power-up value only, no reset clears them
  logic [REGION_WORDS/2-1:0] written_r = '0;
  seq_e seq_r, seq_nxt;
  logic secure_r, secure_nxt;
  logic lock_r = 1'b0;
  logic prog_r;
  logic [ADDR_W-1:0] burst_r;
  logic burst_act_r;
  rd_word_s rd_r;

  //////////////////////////////////////////////////////////////////////////
  wire logic cyc_u1 = is_cyc(wr_cyc_in, UNLOCK_ADDR1, UNLOCK_DATA1);
  wire logic cyc_u2 = is_cyc(wr_cyc_in, UNLOCK_ADDR2, UNLOCK_DATA2);
  wire logic cyc_entry = is_cyc(wr_cyc_in, UNLOCK_ADDR1, CMD_ENTRY);
  wire logic cyc_exit = is_cyc(wr_cyc_in, UNLOCK_ADDR1, CMD_EXIT);
  wire logic cyc_prog = is_cyc(wr_cyc_in, UNLOCK_ADDR1, CMD_PROGRAM);
  wire logic cyc_lock = is_cyc(wr_cyc_in, UNLOCK_ADDR1, CMD_LOCK);
  wire logic [REGION_AW-1:0] wr_idx = wr_cyc_in.addr[REGION_AW-1:0];
  wire logic wr_in_region = wr_cyc_in.addr[ADDR_W-1:REGION_AW] == '0;
  wire logic wr_cust = wr_in_region && wr_idx >= CUST_BASE;
  wire logic [6:0] wr_cidx = wr_idx[6:0];
  // program only customer words not yet written, never after lock
  wire logic prog_ok = secure_r && !lock_r && !embedded_busy_in &&
    wr_cust && !written_r[wr_cidx];
  wire logic do_prog = wr_in && seq_r == SEQ_PROG && prog_ok;
  wire logic do_lock = wr_in && seq_r == SEQ_LOCK && secure_r && !lock_r &&
    !embedded_busy_in;

  always_comb begin
    seq_nxt = seq_r;
    secure_nxt = secure_r;
    if (wr_in) begin
      seq_nxt = SEQ_IDLE;
      case (seq_r)
        SEQ_IDLE: if (cyc_u1) seq_nxt = SEQ_UNLK1;
        SEQ_UNLK1: if (cyc_u2) seq_nxt = SEQ_UNLK2;
        SEQ_UNLK2: begin
          if (cyc_entry) secure_nxt = 1'b1;
          else if (cyc_exit) secure_nxt = 1'b0;
          else if (cyc_prog && secure_r) seq_nxt = SEQ_PROG;
          else if (cyc_lock && secure_r) seq_nxt = SEQ_LOCK;
        end
        SEQ_PROG: seq_nxt = SEQ_IDLE;
        SEQ_LOCK: seq_nxt = SEQ_IDLE;
        default: seq_nxt = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      seq_r <= SEQ_IDLE;
      secure_r <= 1'b0;
      prog_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      secure_r <= secure_nxt;
      prog_r <= do_prog;
    end
  end

  // lock and written marks are nonvolatile: no reset clears them
  always_ff @(posedge core_clk_in) begin
    if (do_lock) lock_r <= 1'b1;
    if (do_prog) begin
      written_r[wr_cidx] <= 1'b1;
      mem_r[wr_idx] <= wr_cyc_in.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // burst address: wraps inside region in secure sector 0, else linear
  wire logic brst_sec0 = secure_r && burst_r[ADDR_W-1:SECTOR0_AW] == '0;
  wire logic [ADDR_W-1:0] burst_inc =
    brst_sec0 ? {burst_r[ADDR_W-1:REGION_AW], burst_r[REGION_AW-1:0] +
    8'h01} : burst_r + 24'h000001;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      burst_r <= '0;
      burst_act_r <= 1'b0;
    end else if (burst_start_in) begin
      burst_r <= rd_addr_in;
      burst_act_r <= 1'b1;
    end else if (burst_next_in && burst_act_r) begin
      burst_r <= burst_inc;
    end
  end

  wire logic use_burst = burst_next_in && burst_act_r;
  wire logic [ADDR_W-1:0] cur_addr = use_burst ? burst_inc : rd_addr_in;
  wire logic hit_sec0 = secure_r &&
    cur_addr[ADDR_W-1:SECTOR0_AW] == '0;
  wire logic in_span = cur_addr[SECTOR0_AW-1:REGION_AW] == '0;
  wire logic [REGION_AW-1:0] ridx = cur_addr[REGION_AW-1:0];
  wire logic cust_rd = ridx >= CUST_BASE;
  wire logic word_set = cust_rd ? written_r[ridx[6:0]] : 1'b1;
  wire logic [DATA_W-1:0] sec_word = word_set ? mem_r[ridx] : ERASED_WORD;
  wire logic [DATA_W-1:0] id_word = (rd_addr_in[REGION_AW-1:0] ==
    ID_LOCK_ADDR) ? ({{(DATA_W-2){1'b0}}, 2'b10} << CUST_FLAG_BIT) |
    ({{(DATA_W-1){1'b0}}, lock_r} << CUST_FLAG_BIT) : '0;
  wire logic [DATA_W-1:0] sel_word =
    id_rd_in ? id_word :
    !hit_sec0 ? array_data_in :
    (embedded_busy_in || !in_span) ? INVALID_DATA :
    sec_word;
  // undefined past top: flagged invalid, host must not rely on it
  wire logic past_top = use_burst && burst_r == MAX_ADDR && !brst_sec0;
  wire logic rd_ok = !(hit_sec0 && (embedded_busy_in || !in_span)) &&
    !past_top;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_r <= '0;
    end else if (rd_in || use_burst || id_rd_in) begin
      rd_r <= '{valid: rd_ok || id_rd_in, data: sel_word};
    end else begin
      rd_r.valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign rd_out = rd_r;
  assign array_addr_out = cur_addr;
  assign secure_mode_out = secure_r;
  assign bank_op_allow_out = !(secure_r && op_bank_in == '0);
  assign prog_busy_out = prog_r;
  assign accel_allow_out = !(seq_r == SEQ_PROG || prog_r);
  assign customer_lock_flag_out = lock_r;

  //////////////////////////////////////////////////////////////////////////
  sequence s_unlock;
    wr_in && cyc_u1 && seq_r == SEQ_IDLE ##1 wr_in && cyc_u2;
  endsequence
  property p_entry;
    @(posedge core_clk_in) disable iff (srst_in)
    s_unlock ##1 (wr_in && cyc_entry) |=> secure_r;
  endproperty
  a_entry: assert property (p_entry) else $error("entry failed");
  property p_exit;
    @(posedge core_clk_in) disable iff (srst_in)
    s_unlock ##1 (wr_in && cyc_exit) |=> !secure_r;
  endproperty
  a_exit: assert property (p_exit) else $error("exit failed");
  property p_reset;
    @(posedge core_clk_in) srst_in |=> !secure_r && seq_r == SEQ_IDLE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset kept mode");
  property p_abandon;
    @(posedge core_clk_in) disable iff (srst_in)
    wr_in && seq_r == SEQ_UNLK1 && !cyc_u2 |=>
      seq_r == SEQ_IDLE && $stable(secure_r);
  endproperty
  a_abandon: assert property (p_abandon) else $error("bad seq kept");
  property p_lock_sticky;
    @(posedge core_clk_in) lock_r |=> lock_r;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock cleared");
  property p_busy_invalid;
    @(posedge core_clk_in) disable iff (srst_in)
    rd_in && !use_burst && !id_rd_in && hit_sec0 && embedded_busy_in |=>
      !rd_out.valid && rd_out.data == INVALID_DATA;
  endproperty
  a_busy_invalid: assert property (p_busy_invalid)
    else $error("busy read valid");
  property p_other_sector;
    @(posedge core_clk_in) disable iff (srst_in)
    rd_in && !use_burst && !id_rd_in && !hit_sec0 |=>
      rd_out.data == $past(array_data_in);
  endproperty
  a_other_sector: assert property (p_other_sector)
    else $error("array data lost");
  property p_wrap;
    @(posedge core_clk_in) disable iff (srst_in)
    burst_next_in && burst_act_r && !burst_start_in && brst_sec0 &&
      burst_r[REGION_AW-1:0] == 8'hff |=> burst_r[REGION_AW-1:0] == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no burst wrap");
  property p_bank0;
    @(posedge core_clk_in) disable iff (srst_in)
    secure_r && op_bank_in == '0 |-> !bank_op_allow_out;
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank0 allowed");
endmodule
`default_nettype wire

// file: verif/host_model.sv
// host memory controller model issuing flash command and read cycles
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in, // core clock
  output secure_region_pkg::wr_cycle_s wr_cyc_out, // write addr/data
  output logic wr_out, // write strobe
  output logic [3:0] strb_out, // next, burst start, id, read
  output logic [23:0] addr_out // read address
);
  import secure_region_pkg::*;
  initial begin
    wr_cyc_out = '0;
    wr_out = 1'b0;
    strb_out = 4'h0;
    addr_out = 24'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // tasks are entered at a rising edge; writes run back to back
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    wr_cyc_out <= '{a, d};
    wr_out <= 1'b1;
    @(posedge clk_in);
  endtask
  // released lines are inverted so stale values never look valid
  task automatic rel();
    wr_out <= 1'b0;
    wr_cyc_out <= ~wr_cyc_out;
  endtask
  // unlock pair, then command word at the first unlock address
  task automatic cmd(input logic [15:0] c);
    wr({12'h0, UNLOCK_ADDR1}, UNLOCK_DATA1);
    wr({12'h0, UNLOCK_ADDR2}, UNLOCK_DATA2);
    wr({12'h0, UNLOCK_ADDR1}, c);
    rel();
  endtask
  // kind 0 read, 1 id read, 2 burst start, 3 burst next
  task automatic rq(input logic [1:0] k, input logic [23:0] a);
    addr_out <= a;
    strb_out <= 4'h1 << k;
    @(posedge clk_in);
    strb_out <= 4'h0;
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the secure region access block
// assumes the host model drives all command and read strobes
`timescale 1ns/1ps
`default_nettype none
module tb;
  import secure_region_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic busy = 1'b0;
  logic [BANK_W-1:0] bank = 4'h0;
  logic [31:0] rng = 32'h0000000e;
  int mismatches = 0;
  int cmp_count = 0;
  logic [DATA_W-1:0] mem_exp [128];
  logic [127:0] wr_exp = '0;
  logic locked = 1'b0;
  logic [7:0] j;
  wr_cycle_s wr_cyc;
  logic wr;
  logic [3:0] strb;
  logic [ADDR_W-1:0] addr;
  rd_word_s rd;
  logic [ADDR_W-1:0] arr_addr;
  logic secure;
  logic bank_ok;
  logic accel_ok;
  logic pbusy;
  logic cust_flag;

  always #25 clk = ~clk;

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  // array model: word derived from its address
  function automatic logic [15:0] arr_word(input logic [23:0] a);
    arr_word = a[15:0] ^ 16'h5a5a;
  endfunction
  function automatic logic [15:0] exp_word(input logic [7:0] i);
    exp_word = wr_exp[i[6:0]] ? mem_exp[i[6:0]] : ERASED_WORD;
  endfunction
  function automatic logic [15:0] id_exp(input logic l);
    id_exp = (16'h0001 << FACT_FLAG_BIT) | (16'(l) << CUST_FLAG_BIT);
  endfunction

  wire logic [DATA_W-1:0] arr_data = arr_word(arr_addr);

  host_model u_host (
    .clk_in(clk),
    .wr_cyc_out(wr_cyc),
    .wr_out(wr),
    .strb_out(strb),
    .addr_out(addr)
  );

  secure_region_access uut (
    .core_clk_in(clk),
    .srst_in(srst),
    .wr_in(wr),
    .wr_cyc_in(wr_cyc),
    .rd_in(strb[0]),
    .rd_addr_in(addr),
    .burst_start_in(strb[2]),
    .burst_next_in(strb[3]),
    .id_rd_in(strb[1]),
    .embedded_busy_in(busy),
    .array_data_in(arr_data),
    .op_bank_in(bank),
    .rd_out(rd),
    .array_addr_out(arr_addr),
    .secure_mode_out(secure),
    .bank_op_allow_out(bank_ok),
    .accel_allow_out(accel_ok),
    .prog_busy_out(pbusy),
    .customer_lock_flag_out(cust_flag)
  );

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // read request, answer checked mid-cycle while it stands
  task automatic rd_chk(input logic [1:0] k, input logic [23:0] a,
                        input logic v, input logic [15:0] d,
                        input logic [15:0] m);
    u_host.rq(k, a);
    @(negedge clk);
    check(rd.valid, v);
    check(rd.data & m, d & m);
    @(posedge clk);
  endtask
  // program one word in secure mode, model decides acceptance
  task automatic prog(input logic [7:0] idx, input logic [15:0] d);
    logic ok;
    ok = !locked && idx >= CUST_BASE && !wr_exp[idx[6:0]];
    u_host.wr({12'h0, UNLOCK_ADDR1}, UNLOCK_DATA1);
    u_host.wr({12'h0, UNLOCK_ADDR2}, UNLOCK_DATA2);
    u_host.wr({12'h0, UNLOCK_ADDR1}, CMD_PROGRAM);
    u_host.rel();
    @(negedge clk);
    check(accel_ok, 1'b0);
    @(posedge clk);
    u_host.wr({16'h0000, idx}, d);
    u_host.rel();
    @(negedge clk);
    check(pbusy, ok);
    if (ok) begin
      wr_exp[idx[6:0]] = 1'b1;
      mem_exp[idx[6:0]] = d;
    end
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(secure, 1'b0);
    check(rd.valid, 1'b0);
    @(posedge clk);
    rd_chk(2'd0, 24'h000010, 1'b1, arr_word(24'h000010), 16'hffff);
    rd_chk(2'd1, 24'h000003, 1'b1, id_exp(1'b0), 16'hffff);
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      rd_chk(2'd0, rng[23:0], 1'b1, arr_word(rng[23:0]), 16'hffff);
    end
    u_host.cmd(CMD_ENTRY);
    @(negedge clk);
    check(secure, 1'b1);
    check(accel_ok, 1'b1);
    @(posedge clk);
    bank <= 4'h0;
    @(negedge clk);
    check(bank_ok, 1'b0);
    @(posedge clk);
    rng = xs(rng);
    bank <= rng[3:0] | 4'h1;
    @(negedge clk);
    check(bank_ok, 1'b1);
    @(posedge clk);
    rd_chk(2'd0, 24'h000085, 1'b1, ERASED_WORD, 16'hffff);
    prog(8'h10, 16'h1234);
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      prog({1'b1, rng[6:0]}, rng[31:16]);
    end
    prog(8'h80, 16'h0f0f);
    prog(8'h80, 16'hf0f0);
    for (int i = 0; i < 128; i++) begin
      j = 8'h80 + 8'(i);
      rd_chk(2'd0, {16'h0000, j}, 1'b1, exp_word(j), 16'hffff);
    end
    busy <= 1'b1;
    rd_chk(2'd0, 24'h000081, 1'b0, INVALID_DATA, 16'hffff);
    busy <= 1'b0;
    rd_chk(2'd0, 24'h000100, 1'b0, INVALID_DATA, 16'hffff);
    rd_chk(2'd0, 24'h008000, 1'b1, arr_word(24'h008000), 16'hffff);
    // burst from fe wraps through factory words back into customer
    u_host.rq(2'd2, 24'h0000fe);
    for (int i = 0; i < 131; i++) begin
      j = 8'hff + 8'(i);
      rd_chk(2'd3, 24'h000000, 1'b1, exp_word(j),
             j >= CUST_BASE ? 16'hffff : 16'h0000);
    end
    u_host.wr({12'h0, UNLOCK_ADDR1}, UNLOCK_DATA1);
    u_host.wr({12'h0, UNLOCK_ADDR2}, UNLOCK_DATA2);
    u_host.wr({12'h0, UNLOCK_ADDR1}, CMD_LOCK);
    u_host.wr(24'h000000, 16'h0000);
    u_host.rel();
    locked = 1'b1;
    @(negedge clk);
    check(cust_flag, 1'b1);
    @(posedge clk);
    rd_chk(2'd1, 24'h000003, 1'b1, id_exp(1'b1), 16'hffff);
    prog(8'hc3, 16'h5555);
    rd_chk(2'd0, 24'h0000c3, 1'b1, exp_word(8'hc3), 16'hffff);
    u_host.wr({12'h0, UNLOCK_ADDR1}, UNLOCK_DATA1);
    u_host.wr({12'h0, UNLOCK_ADDR2}, 16'h0056);
    u_host.wr({12'h0, UNLOCK_ADDR1}, CMD_EXIT);
    u_host.rel();
    @(negedge clk);
    check(secure, 1'b1);
    @(posedge clk);
    u_host.cmd(CMD_EXIT);
    @(negedge clk);
    check(secure, 1'b0);
    @(posedge clk);
    rd_chk(2'd0, 24'h000085, 1'b1, arr_word(24'h000085), 16'hffff);
    u_host.cmd(CMD_ENTRY);
    srst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(secure, 1'b0);
    check(cust_flag, 1'b1);
    @(posedge clk);
    u_host.rq(2'd2, 24'hffffff);
    rd_chk(2'd3, 24'h000000, 1'b0, 16'h0000, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
